// File: rtl/vrd_fetch.sv
module vrd_fetch #(
  parameter int CYCLES = vrd_pkg::FETCH_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic enable,
  input wire logic [7:0] rom_data,
  output logic busy,
  output logic [7:0] byte_q
);
  localparam int CW = $clog2(CYCLES + 1);
  initial begin
    if (CYCLES < 1) begin
      $error("vrd_fetch needs CYCLES of at least 1");
    end
  end
  vrd_pkg::vrd_state_type state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [7:0] byte_d;
  // Count the fetch time
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    byte_d = byte_q;
    case (state_q)
      vrd_pkg::VRD_IDLE: begin
        if (start && enable) begin
          state_d = vrd_pkg::VRD_FETCH;
          cnt_d = CW'(CYCLES - 1);
        end
      end
      vrd_pkg::VRD_FETCH: begin
        if (start) begin
          cnt_d = CW'(CYCLES - 1);
        end else if (cnt_q == '0) begin
          state_d = vrd_pkg::VRD_IDLE;
          byte_d = rom_data;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
        if (!enable) begin
          state_d = vrd_pkg::VRD_IDLE;
        end
      end
      default: state_d = vrd_pkg::VRD_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= vrd_pkg::VRD_IDLE;
      cnt_q <= '0;
      byte_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      byte_q <= byte_d;
    end
  end
  assign busy = (state_q == vrd_pkg::VRD_FETCH);
endmodule

// File: rtl/vrd_pkg.sv
// Function
// - The block drives one 12-bit current DAC output from the sample registers.
// - The 12-bit sample is the high nibble of the low sample register under the whole high sample register.
// - The low nibble of the low sample register always reads as zero.
// - Sixteen volume levels come from the high nibble of the loudness register at 29H.
// - The low nibble of the loudness register always reads as zero.
// - Control bit 1 enables the DAC when one and disables it when zero.
// - With the DAC disabled no valid analogue output is produced.
// - Control bit 2 enables the voice ROM circuit, and while it is zero no ROM data is reachable.
// - Control bit 4 selects address latch set 0 or set 1.
// - Control bit 7 picks the 32kHz crystal start mode, zero for speed-up, and resets to zero.
// - Each ROM location is one byte, addressed by 24 bits in high, middle and low registers.
// - A fetch takes at least 4 us before the byte is latched, and software waits that long.
// - The latched ROM byte is read from the data register at 2AH.
package vrd_pkg;
  localparam logic [7:0] ADDR0_HIGH_OFS = 8'h18;
  localparam logic [7:0] ADDR0_MID_OFS = 8'h19;
  localparam logic [7:0] ADDR0_LOW_OFS = 8'h1A;
  localparam logic [7:0] ADDR1_HIGH_OFS = 8'h1B;
  localparam logic [7:0] ADDR1_MID_OFS = 8'h1C;
  localparam logic [7:0] ADDR1_LOW_OFS = 8'h1D;
  localparam logic [7:0] VOICE_CONTROL_OFS = 8'h26;
  localparam logic [7:0] SAMPLE_LOW_OFS = 8'h27;
  localparam logic [7:0] SAMPLE_HIGH_OFS = 8'h28;
  localparam logic [7:0] LOUDNESS_OFS = 8'h29;
  localparam logic [7:0] ROM_READ_OFS = 8'h2A;
  localparam int DAC_EN_BIT = 1;
  localparam int ROM_EN_BIT = 2;
  localparam int SET_SEL_BIT = 4;
  localparam int XTAL_NORMAL_BIT = 7;
  localparam logic [7:0] VOICE_CONTROL_MASK = 8'h96;
  localparam logic [7:0] VOICE_CONTROL_RST = 8'h00;
  localparam logic [7:0] HIGH_NIBBLE_MASK = 8'hF0;
  localparam int CLK_HZ = 10000000;
  localparam int FETCH_NS = 4000;
  localparam int FETCH_CYCLES = (FETCH_NS * (CLK_HZ / 1000000) + 999) / 1000;
  typedef enum logic [0:0] {
    VRD_IDLE = 1'b0,
    VRD_FETCH = 1'b1
  } vrd_state_type;
endpackage

// File: rtl/vrd_top.sv
module vrd_top #(
  parameter int FETCH_CYCLES = vrd_pkg::FETCH_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [23:0] rom_addr,
  output logic rom_enable,
  input wire logic [7:0] rom_data,
  output logic [11:0] dac_code,
  output logic [3:0] dac_volume,
  output logic dac_enable,
  output logic xtal_normal_start,
  output logic fetch_busy
);
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] slo_q, slo_d, shi_q, shi_d, vol_q, vol_d;
  logic [7:0] a0h_q, a0h_d, a0m_q, a0m_d, a0l_q, a0l_d;
  logic [7:0] a1h_q, a1h_d, a1m_q, a1m_d, a1l_q, a1l_d;
  logic [11:0] dac_q, dac_d;
  logic [7:0] rom_byte;
  logic wr_sel_set, sel;

  // Assertions below need a fetch of at least three cycles
  if (FETCH_CYCLES < 3) begin : g_bad_cycles
    $error("vrd_top needs FETCH_CYCLES of at least 3");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  always_comb begin
    ctrl_d = ctrl_q;
    slo_d = slo_q;
    shi_d = shi_q;
    vol_d = vol_q;
    a0h_d = a0h_q;
    a0m_d = a0m_q;
    a0l_d = a0l_q;
    a1h_d = a1h_q;
    a1m_d = a1m_q;
    a1l_d = a1l_q;
    if (reg_wr) begin
      if (hit(reg_addr, vrd_pkg::VOICE_CONTROL_OFS)) ctrl_d = reg_wdata & vrd_pkg::VOICE_CONTROL_MASK;
      if (hit(reg_addr, vrd_pkg::SAMPLE_LOW_OFS)) slo_d = reg_wdata & vrd_pkg::HIGH_NIBBLE_MASK;
      if (hit(reg_addr, vrd_pkg::SAMPLE_HIGH_OFS)) shi_d = reg_wdata;
      if (hit(reg_addr, vrd_pkg::LOUDNESS_OFS)) vol_d = reg_wdata & vrd_pkg::HIGH_NIBBLE_MASK;
      if (hit(reg_addr, vrd_pkg::ADDR0_HIGH_OFS)) a0h_d = reg_wdata;
      if (hit(reg_addr, vrd_pkg::ADDR0_MID_OFS)) a0m_d = reg_wdata;
      if (hit(reg_addr, vrd_pkg::ADDR0_LOW_OFS)) a0l_d = reg_wdata;
      if (hit(reg_addr, vrd_pkg::ADDR1_HIGH_OFS)) a1h_d = reg_wdata;
      if (hit(reg_addr, vrd_pkg::ADDR1_MID_OFS)) a1m_d = reg_wdata;
      if (hit(reg_addr, vrd_pkg::ADDR1_LOW_OFS)) a1l_d = reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= vrd_pkg::VOICE_CONTROL_RST;
      slo_q <= 8'h00;
      shi_q <= 8'h00;
      vol_q <= 8'h00;
      a0h_q <= 8'h00;
      a0m_q <= 8'h00;
      a0l_q <= 8'h00;
      a1h_q <= 8'h00;
      a1m_q <= 8'h00;
      a1l_q <= 8'h00;
      dac_q <= 12'h000;
    end else begin
      ctrl_q <= ctrl_d;
      slo_q <= slo_d;
      shi_q <= shi_d;
      vol_q <= vol_d;
      a0h_q <= a0h_d;
      a0m_q <= a0m_d;
      a0l_q <= a0l_d;
      a1h_q <= a1h_d;
      a1m_q <= a1m_d;
      a1l_q <= a1l_d;
      dac_q <= dac_d;
    end
  end

  assign sel = ctrl_q[vrd_pkg::SET_SEL_BIT];
  assign rom_addr = sel ? {a1h_q, a1m_q, a1l_q} : {a0h_q, a0m_q, a0l_q};
  assign wr_sel_set = reg_wr && (sel ?
    (hit(reg_addr, vrd_pkg::ADDR1_HIGH_OFS) || hit(reg_addr, vrd_pkg::ADDR1_MID_OFS) ||
     hit(reg_addr, vrd_pkg::ADDR1_LOW_OFS)) :
    (hit(reg_addr, vrd_pkg::ADDR0_HIGH_OFS) || hit(reg_addr, vrd_pkg::ADDR0_MID_OFS) ||
     hit(reg_addr, vrd_pkg::ADDR0_LOW_OFS)));
  assign rom_enable = ctrl_q[vrd_pkg::ROM_EN_BIT];

  always_comb begin
    dac_d = ctrl_d[vrd_pkg::DAC_EN_BIT] ? {shi_d, slo_d[7:4]} : 12'h000;
  end
  assign dac_code = dac_q;
  assign dac_enable = ctrl_q[vrd_pkg::DAC_EN_BIT];
  assign dac_volume = dac_enable ? vol_q[7:4] : 4'h0;
  assign xtal_normal_start = ctrl_q[vrd_pkg::XTAL_NORMAL_BIT];

  // Fetch restarts on each byte written to the selected address set while the ROM is enabled, so the last byte written sets the wait
  vrd_fetch #(
    .CYCLES(FETCH_CYCLES)
  ) u_fetch (
    .clk(clk),
    .rstn(rstn),
    .start(wr_sel_set),
    .enable(rom_enable),
    .rom_data(rom_data),
    .busy(fetch_busy),
    .byte_q(rom_byte)
  );

  // Reads are combinational on the address
  always_comb begin
    reg_rdata = 8'h00;
    case (reg_addr)
      vrd_pkg::VOICE_CONTROL_OFS: reg_rdata = ctrl_q;
      vrd_pkg::SAMPLE_LOW_OFS: reg_rdata = slo_q;
      vrd_pkg::SAMPLE_HIGH_OFS: reg_rdata = shi_q;
      vrd_pkg::LOUDNESS_OFS: reg_rdata = vol_q;
      vrd_pkg::ADDR0_HIGH_OFS: reg_rdata = a0h_q;
      vrd_pkg::ADDR0_MID_OFS: reg_rdata = a0m_q;
      vrd_pkg::ADDR0_LOW_OFS: reg_rdata = a0l_q;
      vrd_pkg::ADDR1_HIGH_OFS: reg_rdata = a1h_q;
      vrd_pkg::ADDR1_MID_OFS: reg_rdata = a1m_q;
      vrd_pkg::ADDR1_LOW_OFS: reg_rdata = a1l_q;
      vrd_pkg::ROM_READ_OFS: reg_rdata = rom_enable ? rom_byte : 8'h00;
      default: reg_rdata = 8'h00;
    endcase
  end

  // busy run length
  // Counter instead of a long repetition, which would not scale to 40 cycles
  localparam int RW = $clog2(FETCH_CYCLES + 2);
  logic [RW-1:0] run_q, run_d;
  always_comb begin
    run_d = '0;
    if (!wr_sel_set && fetch_busy) begin
      run_d = run_q + RW'(1);
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      run_q <= '0;
    end else begin
      run_q <= run_d;
    end
  end

  sequence s_addr_write;
    wr_sel_set && rom_enable;
  endsequence
  sequence s_rom_held;
    rom_enable [*3];
  endsequence
  sequence s_busy_run;
    fetch_busy && $past(fetch_busy) && $past(fetch_busy, 2);
  endsequence

  property p_low_nibble;
    @(posedge clk) disable iff (!rstn) (reg_addr == vrd_pkg::SAMPLE_LOW_OFS) |-> reg_rdata[3:0] == 4'h0;
  endproperty
  a_low_nibble: assert property (p_low_nibble) else $error("sample low nibble not zero");
  property p_vol_nibble;
    @(posedge clk) disable iff (!rstn) (reg_addr == vrd_pkg::LOUDNESS_OFS) |-> reg_rdata[3:0] == 4'h0;
  endproperty
  a_vol_nibble: assert property (p_vol_nibble) else $error("volume low nibble not zero");
  property p_ctrl_unused;
    @(posedge clk) disable iff (!rstn) (ctrl_q & 8'h69) == 8'h00;
  endproperty
  a_ctrl_unused: assert property (p_ctrl_unused) else $error("unused control bit set");
  property p_dac_off;
    @(posedge clk) disable iff (!rstn) !dac_enable |-> dac_code == 12'h000;
  endproperty
  a_dac_off: assert property (p_dac_off) else $error("DAC code while disabled");
  property p_dac_code;
    @(posedge clk) disable iff (!rstn) dac_enable |-> dac_code == {shi_q, slo_q[7:4]};
  endproperty
  a_dac_code: assert property (p_dac_code) else $error("DAC code mismatch");
  property p_rom_off;
    @(posedge clk) disable iff (!rstn)
      (!rom_enable && reg_addr == vrd_pkg::ROM_READ_OFS) |-> reg_rdata == 8'h00;
  endproperty
  a_rom_off: assert property (p_rom_off) else $error("ROM data while disabled");
  property p_fetch_wait;
    @(posedge clk) disable iff (!rstn) s_addr_write ##1 s_rom_held |-> s_busy_run;
  endproperty
  a_fetch_wait: assert property (p_fetch_wait) else $error("fetch ended too soon");
  property p_old_data;
    @(posedge clk) disable iff (!rstn) fetch_busy ##1 fetch_busy |-> $stable(rom_byte);
  endproperty
  a_old_data: assert property (p_old_data) else $error("data changed mid fetch");
  property p_sel;
    @(posedge clk) disable iff (!rstn) sel |-> rom_addr == {a1h_q, a1m_q, a1l_q};
  endproperty
  a_sel: assert property (p_sel) else $error("wrong address set");

  property p_sel0;
    @(posedge clk) disable iff (!rstn) !sel |-> rom_addr == {a0h_q, a0m_q, a0l_q};
  endproperty
  a_sel0: assert property (p_sel0) else $error("wrong address set");

  property p_run_max;
    @(posedge clk) disable iff (!rstn) run_q <= RW'(FETCH_CYCLES);
  endproperty
  a_run_max: assert property (p_run_max) else $error("fetch ran too long");

  property p_run_end;
    @(posedge clk) disable iff (!rstn) run_q == RW'(FETCH_CYCLES) |-> !fetch_busy;
  endproperty
  a_run_end: assert property (p_run_end) else $error("fetch did not end");

  property p_fetch_latch;
    @(posedge clk) disable iff (!rstn)
      (fetch_busy && rom_enable && !wr_sel_set) ##1 !fetch_busy |-> rom_byte == $past(rom_data);
  endproperty
  a_fetch_latch: assert property (p_fetch_latch) else $error("fetched byte wrong");

  property p_fetch_start;
    @(posedge clk) disable iff (!rstn) s_addr_write |=> fetch_busy;
  endproperty
  a_fetch_start: assert property (p_fetch_start) else $error("fetch not started");

  property p_fetch_off;
    @(posedge clk) disable iff (!rstn) !rom_enable |=> !fetch_busy;
  endproperty
  a_fetch_off: assert property (p_fetch_off) else $error("fetch while disabled");

  property p_rom_en;
    @(posedge clk) disable iff (!rstn) rom_enable == ctrl_q[vrd_pkg::ROM_EN_BIT];
  endproperty
  a_rom_en: assert property (p_rom_en) else $error("ROM enable wrong");

  property p_rom_read;
    @(posedge clk) disable iff (!rstn)
      (rom_enable && reg_addr == vrd_pkg::ROM_READ_OFS) |-> reg_rdata == rom_byte;
  endproperty
  a_rom_read: assert property (p_rom_read) else $error("ROM byte read wrong");

  property p_ctrl_write;
    @(posedge clk) disable iff (!rstn) (reg_wr && hit(reg_addr, vrd_pkg::VOICE_CONTROL_OFS))
      |=> ctrl_q == ($past(reg_wdata) & vrd_pkg::VOICE_CONTROL_MASK);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  property p_ctrl_read;
    @(posedge clk) disable iff (!rstn) (reg_addr == vrd_pkg::VOICE_CONTROL_OFS) |-> reg_rdata == ctrl_q;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

  property p_ctrl_reset;
    @(posedge clk) !rstn |=> ctrl_q == vrd_pkg::VOICE_CONTROL_RST;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control reset wrong");

  property p_xtal;
    @(posedge clk) disable iff (!rstn) xtal_normal_start == ctrl_q[vrd_pkg::XTAL_NORMAL_BIT];
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal mode wrong");

  property p_dac_en;
    @(posedge clk) disable iff (!rstn) dac_enable == ctrl_q[vrd_pkg::DAC_EN_BIT];
  endproperty
  a_dac_en: assert property (p_dac_en) else $error("DAC enable wrong");

  property p_slo_write;
    @(posedge clk) disable iff (!rstn) (reg_wr && hit(reg_addr, vrd_pkg::SAMPLE_LOW_OFS))
      |=> slo_q == ($past(reg_wdata) & vrd_pkg::HIGH_NIBBLE_MASK);
  endproperty
  a_slo_write: assert property (p_slo_write) else $error("sample low write lost");

  property p_shi_write;
    @(posedge clk) disable iff (!rstn)
      (reg_wr && hit(reg_addr, vrd_pkg::SAMPLE_HIGH_OFS)) |=> shi_q == $past(reg_wdata);
  endproperty
  a_shi_write: assert property (p_shi_write) else $error("sample high write lost");

  property p_vol_write;
    @(posedge clk) disable iff (!rstn) (reg_wr && hit(reg_addr, vrd_pkg::LOUDNESS_OFS))
      |=> vol_q == ($past(reg_wdata) & vrd_pkg::HIGH_NIBBLE_MASK);
  endproperty
  a_vol_write: assert property (p_vol_write) else $error("loudness write lost");

  property p_vol_out;
    @(posedge clk) disable iff (!rstn) dac_enable |-> dac_volume == vol_q[7:4];
  endproperty
  a_vol_out: assert property (p_vol_out) else $error("volume output wrong");

  property p_vol_off;
    @(posedge clk) disable iff (!rstn) !dac_enable |-> dac_volume == 4'h0;
  endproperty
  a_vol_off: assert property (p_vol_off) else $error("volume while disabled");

  property p_a0h_write;
    @(posedge clk) disable iff (!rstn)
      (reg_wr && hit(reg_addr, vrd_pkg::ADDR0_HIGH_OFS)) |=> a0h_q == $past(reg_wdata);
  endproperty
  a_a0h_write: assert property (p_a0h_write) else $error("address write lost");

  property p_a0m_write;
    @(posedge clk) disable iff (!rstn)
      (reg_wr && hit(reg_addr, vrd_pkg::ADDR0_MID_OFS)) |=> a0m_q == $past(reg_wdata);
  endproperty
  a_a0m_write: assert property (p_a0m_write) else $error("address write lost");

  property p_a0l_write;
    @(posedge clk) disable iff (!rstn)
      (reg_wr && hit(reg_addr, vrd_pkg::ADDR0_LOW_OFS)) |=> a0l_q == $past(reg_wdata);
  endproperty
  a_a0l_write: assert property (p_a0l_write) else $error("address write lost");

  property p_a1h_write;
    @(posedge clk) disable iff (!rstn)
      (reg_wr && hit(reg_addr, vrd_pkg::ADDR1_HIGH_OFS)) |=> a1h_q == $past(reg_wdata);
  endproperty
  a_a1h_write: assert property (p_a1h_write) else $error("address write lost");

  property p_a1m_write;
    @(posedge clk) disable iff (!rstn)
      (reg_wr && hit(reg_addr, vrd_pkg::ADDR1_MID_OFS)) |=> a1m_q == $past(reg_wdata);
  endproperty
  a_a1m_write: assert property (p_a1m_write) else $error("address write lost");

  property p_a1l_write;
    @(posedge clk) disable iff (!rstn)
      (reg_wr && hit(reg_addr, vrd_pkg::ADDR1_LOW_OFS)) |=> a1l_q == $past(reg_wdata);
  endproperty
  a_a1l_write: assert property (p_a1l_write) else $error("address write lost");
endmodule

// File: tb/voice_rom_dac_control_tb.sv
module voice_rom_dac_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Short fetch keeps the run brief
  localparam int FC = 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] rom_data;
  logic [23:0] rom_addr;
  logic rom_enable;
  logic dac_enable;
  logic xtal_normal_start;
  logic fetch_busy;
  logic [11:0] dac_code;
  logic [3:0] dac_volume;
  int n_fail = 0;
  int checks_done = 0;

  always #50 clk = ~clk;

  vrd_top #(.FETCH_CYCLES(FC)) u_vrd_top (
    .clk(clk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .rom_addr(rom_addr),
    .rom_enable(rom_enable),
    .rom_data(rom_data),
    .dac_code(dac_code),
    .dac_volume(dac_volume),
    .dac_enable(dac_enable),
    .xtal_normal_start(xtal_normal_start),
    .fetch_busy(fetch_busy)
  );

  vrd_rom_model u_vrd_rom_model (
    .clk(clk),
    .rom_addr(rom_addr),
    .rom_enable(rom_enable),
    .rom_data(rom_data)
  );

  function automatic logic [7:0] rom_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
  endfunction

  task automatic final_report();
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Called at a falling edge, returns two falling edges later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // Idle edge so the strobe never toggles twice in one step
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    #10;
    chk($sformatf("reg %h", a), 24'(exp), 24'(reg_rdata));
    @(negedge clk);
  endtask

  // Busy cycles still ahead, counted from the falling edge of the call
  task automatic wait_fetch(input int exp);
    int n = 0;
    while (fetch_busy === 1'b1 && n < 100) begin
      n++;
      @(negedge clk);
    end
    if (n >= 100) begin
      n_fail++;
      final_report();
    end
    chk("busy cycles", 24'(exp), 24'(n));
  endtask

  initial begin
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    rd(8'h26, 8'h00);
    chk("xtal", 24'h0, 24'(xtal_normal_start));
    wr(8'h26, 8'hFF);
    rd(8'h26, 8'h96);
    chk("dac_en", 24'h1, 24'(dac_enable));
    chk("rom_en", 24'h1, 24'(rom_enable));
    chk("xtal", 24'h1, 24'(xtal_normal_start));
    wr(8'h27, 8'hAB);
    wr(8'h28, 8'hCD);
    wr(8'h29, 8'h7F);
    rd(8'h27, 8'hA0);
    rd(8'h28, 8'hCD);
    rd(8'h29, 8'h70);
    chk("dac_code", 24'hCDA, 24'(dac_code));
    chk("volume", 24'h7, 24'(dac_volume));
    wr(8'h26, 8'h94);
    chk("dac_code", 24'h0, 24'(dac_code));
    chk("dac_en", 24'h0, 24'(dac_enable));
    // Rom on, set 0, low byte first as software would
    wr(8'h26, 8'h04);
    wr(8'h1A, 8'h07);
    wr(8'h19, 8'h00);
    wr(8'h18, 8'h00);
    wait_fetch(FC - 1);
    chk("rom_addr", 24'h000007, rom_addr);
    rd(8'h2A, rom_byte(24'h000007));
    wr(8'h1A, 8'h08);
    rd(8'h2A, rom_byte(24'h000007));
    wait_fetch(FC - 2);
    rd(8'h2A, rom_byte(24'h000008));
    wr(8'h26, 8'h14);
    wr(8'h1D, 8'h12);
    wr(8'h1C, 8'h34);
    wr(8'h1B, 8'h56);
    wait_fetch(FC - 1);
    chk("rom_addr", 24'h563412, rom_addr);
    rd(8'h2A, rom_byte(24'h563412));
    // Writes to the idle set must not disturb the selected one
    wr(8'h1A, 8'h55);
    chk("busy", 24'h0, 24'(fetch_busy));
    chk("rom_addr", 24'h563412, rom_addr);
    rd(8'h1A, 8'h55);
    wr(8'h26, 8'h10);
    rd(8'h2A, 8'h00);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    wr(8'h26, 8'h02);
    chk("dac_code", 24'hCDA, 24'(dac_code));
    chk("volume", 24'h7, 24'(dac_volume));
    final_report();
  end
endmodule

// File: tb/vrd_rom_model.sv
module vrd_rom_model (
  input wire logic clk,
  input wire logic [23:0] rom_addr,
  input wire logic rom_enable,
  output logic [7:0] rom_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Changing pattern so a disabled store never looks like stale data
  logic [7:0] junk_q = 8'hA5;
  always_ff @(posedge clk) begin
    junk_q <= ~junk_q;
  end
  // byte wide, 24-bit address, toggling junk pattern while off
  always_comb begin
    rom_data = rom_enable ? (rom_addr[7:0] ^ rom_addr[15:8] ^ rom_addr[23:16] ^ 8'h5A) : junk_q;
  end
endmodule
